// ===== hdl/osd_row_pkg.sv
/*
  Shared constants and types for the on-screen-display row header and
  background palette decoder.
  Assumes a byte-wide display RAM written by software and read by the row engine.
*/
package osd_row_pkg;

  // ********************************************************************
  // Display RAM map
  // ********************************************************************
  localparam int RAM_AW = 8;
  localparam logic [7:0] BASIC_PAL_FIRST = 8'h30;
  localparam logic [7:0] BASIC_PAL_LAST = 8'h4F;
  localparam logic [7:0] EXT_PAL_FIRST = 8'h70;
  localparam logic [7:0] EXT_PAL_LAST = 8'h8F;
  localparam logic [7:0] HDR_LINK_OFS = 8'h00;
  localparam logic [7:0] HDR_POS_OFS = 8'h02;
  localparam logic [7:0] HDR_ATTR_OFS = 8'h04;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam int HDR_BYTES = 5;

  // ********************************************************************
  // Palette entry fields
  // ********************************************************************
  localparam int PAL_CENTER_BIT = 15;
  localparam int PAL_OPA_LSB = 9;
  localparam int PAL_RED_LSB = 6;
  localparam int PAL_GRN_LSB = 3;
  localparam int PAL_BLU_LSB = 0;
  localparam logic [2:0] OPACITY_FULL = 3'h7;

  // ********************************************************************
  // Header fields
  // ********************************************************************
  localparam int LINK_FMT_LSB = 14;
  localparam int POS_COUNT_LSB = 10;
  localparam logic [5:0] MAX_CHARS_PAR = 6'h3F;
  localparam logic [5:0] MAX_CHARS_SER = 6'h3D;
  localparam logic [10:0] OFFSET_BIAS = 11'h02F;
  localparam logic [9:0] MIN_LEFT_OFFSET = 10'h001;
  localparam int ATTR_GRID = 7;
  localparam int ATTR_TOP = 6;
  localparam int ATTR_VSCALE = 4;
  localparam int ATTR_HSCALE = 3;
  localparam int ATTR_BLINK = 2;
  localparam int ATTR_ROUND = 1;
  localparam int ATTR_EDGE = 0;
  localparam logic [1:0] SERIAL_LEAD = 2'h2;

  typedef enum logic [1:0] {
    FMT_SERIAL = 2'b00,
    FMT_BASIC = 2'b01,
    FMT_EXTENDED = 2'b10,
    FMT_RESERVED = 2'b11
  } row_format_type;

  typedef struct packed {
    logic centerSwitch;
    logic [2:0] opacity;
    logic [2:0] red;
    logic [2:0] green;
    logic [2:0] blue;
  } back_colour_type;

  typedef struct packed {
    logic [8:0] nextRowPointer;
    row_format_type nextFormat;
    logic [5:0] charsPerRow;
    logic [9:0] leftOffset;
    logic offsetError;
    logic [11:0] startDelay;
    logic glyphGrid;
    logic topHalf;
    logic [2:0] dotHeight;
    logic [2:0] dotWidth;
    logic blinkOn;
    logic smoothOn;
    logic outlineOn;
  } row_setup_type;

endpackage

// ===== hdl/back_palette_decode.sv
/*
  Background palette entry decoder: splits one 16-bit palette word
  into colour fields and decides when the colour change takes effect.
  Assumes the caller supplies the italic state of the preceding character.
*/
`timescale 1ns/1ns
`default_nettype none
module back_palette_decode
  import osd_row_pkg::*;
(
  // Entry word and italic state of the preceding character
  input wire logic [15:0] entryWord,
  input wire logic prevItalic,
  // Decoded colour
  output back_colour_type colour
);

  always_comb begin
    colour.opacity = entryWord[PAL_OPA_LSB +: 3];
    colour.red = entryWord[PAL_RED_LSB +: 3];
    colour.green = entryWord[PAL_GRN_LSB +: 3];
    colour.blue = entryWord[PAL_BLU_LSB +: 3];
    // Slanted predecessor would overlap a left-edge switch
    colour.centerSwitch = entryWord[PAL_CENTER_BIT] | prevItalic;
  end

endmodule // back_palette_decode
`default_nettype wire

// ===== hdl/osd_row_header_bg_palette.sv
/*
  Row header latch and background palette lookup for the OSD engine.
  Holds display RAM as flip-flops, written and read by software over a
  plain strobe port; the engine side fetches a row header on request and
  looks up background colours. Assumes ref_clk drives both sides.
*/
`timescale 1ns/1ns
`default_nettype none
module osd_row_header_bg_palette
  import osd_row_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Software register port
  input wire logic [RAM_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Row control from the display engine
  input wire logic rowStart,
  input wire logic rowDone,
  input wire logic [8:0] rowBase,
  input wire row_format_type rowFormat,
  input wire logic doubleWidthAttr,
  input wire logic doubleHeightAttr,
  // Background lookup
  input wire logic [3:0] backIndex,
  input wire logic extendedPalette,
  input wire logic prevItalic,
  input wire logic charFlashing,
  // Outputs to video mixing
  output row_setup_type rowSetup,
  output logic rowActive,
  output back_colour_type backColour,
  output logic backBlank,
  output logic videoOnly
);

  initial begin
    if (RAM_DEPTH < 256 || RAM_DEPTH > (1 << RAM_AW)) begin
      $error("RAM_DEPTH must cover the full display segment");
    end
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_ROW = 2'b10
  } row_state_type;

  typedef struct packed {
    row_state_type state;
    logic [2:0] fetchCnt;
    logic [7:0] rdData;
    logic [15:0] linkWord;
    logic [15:0] posWord;
    logic [7:0] attrByte;
    row_format_type curFormat;
    logic wideAttr;
    logic tallAttr;
    row_setup_type setup;
    logic active;
    back_colour_type colour;
    logic blank;
    logic videoOnly;
  } ctl_type;

  ctl_type ctl_r;
  ctl_type ctl_nxt;
  logic [7:0] ram_r [RAM_DEPTH];
  logic [7:0] ram_nxt [RAM_DEPTH];

  // ********************************************************************
  // Palette fetch
  // ********************************************************************
  logic [7:0] palAddr;
  logic [15:0] palWord;
  back_colour_type palColour;

  always_comb begin
    // Entry n at base + 2n, even address holds the high byte
    palAddr = (extendedPalette ? EXT_PAL_FIRST : BASIC_PAL_FIRST) + {3'h0, backIndex, 1'b0};
    palWord = {ram_r[palAddr], ram_r[palAddr + ONE_BYTE]};
  end

  back_palette_decode palDecode (
    .entryWord(palWord),
    .prevItalic(prevItalic),
    .colour(palColour)
  );

  // ********************************************************************
  // Display RAM write port
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < RAM_DEPTH; gi++) begin : gRam
      always_comb begin
        ram_nxt[gi] = ram_r[gi];
        if (regWrite && regAddr == RAM_AW'(gi)) begin
          ram_nxt[gi] = regWrData;
        end
      end
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          ram_r[gi] <= 8'h00;
        end else begin
          ram_r[gi] <= ram_nxt[gi];
        end
      end
    end
  endgenerate

  // ********************************************************************
  // Control
  // ********************************************************************
  logic [7:0] hdrAddr;
  logic [7:0] fetchByte;
  logic bigGrid;
  logic wideOn;
  logic tallOn;
  logic hScale;
  logic vScale;
  logic [5:0] cnt;

  always_comb begin
    ctl_nxt = ctl_r;
    hdrAddr = rowBase[7:0] + {5'h00, ctl_r.fetchCnt};
    fetchByte = ram_r[hdrAddr];
    if (regRead) begin
      ctl_nxt.rdData = ram_r[regAddr];
    end

    case (ctl_r.state)
      ST_IDLE: begin
        if (rowStart) begin
          ctl_nxt.state = ST_FETCH;
          ctl_nxt.fetchCnt = 3'h0;
          ctl_nxt.curFormat = rowFormat;
          ctl_nxt.wideAttr = doubleWidthAttr;
          ctl_nxt.tallAttr = doubleHeightAttr;
        end
      end
      ST_FETCH: begin
        case (ctl_r.fetchCnt)
          3'h0: ctl_nxt.linkWord[15:8] = fetchByte;
          3'h1: ctl_nxt.linkWord[7:0] = fetchByte;
          3'h2: ctl_nxt.posWord[15:8] = fetchByte;
          3'h3: ctl_nxt.posWord[7:0] = fetchByte;
          default: ctl_nxt.attrByte = fetchByte;
        endcase
        ctl_nxt.fetchCnt = ctl_r.fetchCnt + 3'h1;
        if (ctl_r.fetchCnt == 3'(HDR_BYTES - 1)) begin
          ctl_nxt.state = ST_ROW;
        end
      end
      ST_ROW: begin
        // Header held still until the engine ends the row
        if (rowDone) begin
          ctl_nxt.state = ST_IDLE;
        end
      end
      default: ctl_nxt.state = ST_IDLE;
    endcase

    ctl_nxt.active = (ctl_nxt.state == ST_ROW);

    // Decode from the latched header only
    ctl_nxt.setup.nextRowPointer = {ctl_r.linkWord[8:1], 1'b0};
    ctl_nxt.setup.nextFormat = row_format_type'(ctl_r.linkWord[LINK_FMT_LSB +: 2]);
    cnt = ctl_r.posWord[POS_COUNT_LSB +: 6];
    // Counts beyond the format limit are clipped
    if (ctl_r.curFormat == FMT_SERIAL && cnt > MAX_CHARS_SER) begin
      cnt = MAX_CHARS_SER;
    end
    ctl_nxt.setup.charsPerRow = cnt;
    ctl_nxt.setup.leftOffset = ctl_r.posWord[9:0];
    ctl_nxt.setup.offsetError = ctl_r.posWord[9:0] < MIN_LEFT_OFFSET;
    // Delay counted in units of two dot clocks
    ctl_nxt.setup.startDelay = {({1'b0, ctl_r.posWord[9:0]} + OFFSET_BIAS), 1'b0};

    bigGrid = ctl_r.attrByte[ATTR_GRID];
    hScale = ctl_r.attrByte[ATTR_HSCALE];
    vScale = ctl_r.attrByte[ATTR_VSCALE];
    wideOn = ctl_r.wideAttr && ctl_r.curFormat != FMT_BASIC;
    tallOn = ctl_r.tallAttr && ctl_r.curFormat != FMT_BASIC;
    ctl_nxt.setup.glyphGrid = bigGrid;
    ctl_nxt.setup.topHalf = ctl_r.attrByte[ATTR_TOP] && bigGrid && tallOn;
    if (!bigGrid) begin
      ctl_nxt.setup.dotHeight = vScale ? 3'h4 : 3'h2;
      ctl_nxt.setup.dotWidth = (hScale && vScale) ? 3'h4 :
                               ((hScale || vScale) ? 3'h3 : 3'h2);
    end else begin
      ctl_nxt.setup.dotWidth = 3'h1 << ({1'b0, hScale} + {1'b0, wideOn});
      ctl_nxt.setup.dotHeight = 3'h1 << ({1'b0, vScale} + {1'b0, tallOn});
    end
    ctl_nxt.setup.blinkOn = ctl_r.attrByte[ATTR_BLINK] && ctl_r.curFormat != FMT_BASIC;
    // Smallest large-grid size has no room for rounding
    ctl_nxt.setup.smoothOn = ctl_r.attrByte[ATTR_ROUND] &&
                             !(bigGrid && !hScale && !vScale && !wideOn && !tallOn);
    ctl_nxt.setup.outlineOn = ctl_r.attrByte[ATTR_EDGE];

    ctl_nxt.colour = palColour;
    ctl_nxt.blank = ctl_r.setup.blinkOn && charFlashing;
    ctl_nxt.videoOnly = (palColour.opacity == 3'h0);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign regRdData = ctl_r.rdData;
  assign rowSetup = ctl_r.setup;
  assign rowActive = ctl_r.active;
  assign backColour = ctl_r.colour;
  assign backBlank = ctl_r.blank;
  assign videoOnly = ctl_r.videoOnly;

endmodule // osd_row_header_bg_palette
`default_nettype wire

// ===== testbench/osd_row_asserts.sv
/* Port checker for the row header and palette block.
   Assumes it is bound to the top module below. */
`timescale 1ns/1ns
`default_nettype none
module osd_row_asserts
  import osd_row_pkg::*;
(
  // Clock, reset, register port
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [RAM_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Row and lookup
  input wire logic rowStart,
  input wire logic rowDone,
  input wire logic prevItalic,
  input wire logic charFlashing,
  input wire row_setup_type rowSetup,
  input wire logic rowActive,
  input wire back_colour_type backColour,
  input wire logic backBlank,
  input wire logic videoOnly
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence wr_then_rd;
    regWrite ##1 (regRead && regAddr == $past(regAddr));
  endsequence
  // Fetch takes five RAM bytes before the row goes live
  sequence fetch_done;
    !rowActive[*4] ##[1:5] rowActive;
  endsequence
  AST_WRRD: assert property (wr_then_rd |=> regRdData == $past(regWrData, 2))
    else $error("read after write stale");
  AST_FETCH: assert property (rowStart && !rowActive |-> fetch_done)
    else $error("row fetch late");
  AST_HOLD: assert property (rowActive && $past(rowActive) && $past(rowActive, 2)
    |-> $stable(rowSetup))
    else $error("row setup moved");
  AST_DONE: assert property (rowDone && rowActive |-> ##[1:2] !rowActive)
    else $error("row did not end");
  AST_NXT: assert property (rowSetup.nextRowPointer[0] == 1'b0)
    else $error("odd next pointer");
  AST_DELAY: assert property (rowActive && $past(rowActive) |->
    rowSetup.startDelay == ({2'h0, rowSetup.leftOffset} + 12'h02F) << 1)
    else $error("start delay wrong");
  AST_OPA: assert property ($past(reset_n, 2) |-> videoOnly == (backColour.opacity == 3'h0))
    else $error("video only wrong");
  AST_CENTER: assert property (prevItalic |=> backColour.centerSwitch)
    else $error("italic not centred");
  AST_BLANK: assert property (backBlank |-> $past(charFlashing))
    else $error("blank without flash");
endmodule // osd_row_asserts
bind osd_row_header_bg_palette osd_row_asserts chk (.*);
`default_nettype wire

// ===== testbench/video_mix_model.sv
/* Video mixing stage: shows the OSD colour or the live picture.
   Assumes block outputs are registered on ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module video_mix_model
  import osd_row_pkg::*;
(
  // Clock, and outputs from the block
  input wire logic ref_clk,
  input wire back_colour_type backColour,
  input wire logic videoOnly,
  // Mixed result
  output logic [8:0] shownRgb
);
  // Transparent background lets the picture through; zero stands for it
  always_ff @(posedge ref_clk) begin
    shownRgb <= videoOnly ? 9'h000 : backColour[8:0];
  end
endmodule // video_mix_model
`default_nettype wire

// ===== testbench/tb.sv
/* Random and corner tests of palettes and row headers.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ns
`default_nettype none
module tb
  import osd_row_pkg::*;
;
  logic ref_clk, reset_n, regWrite, regRead, rowStart, rowDone, rowActive;
  logic [7:0] regAddr, regWrData, regRdData, a, b;
  logic [8:0] rowBase, shownRgb;
  logic doubleWidthAttr, doubleHeightAttr, extendedPalette, prevItalic, charFlashing;
  logic backBlank, videoOnly, dw, dh;
  logic [3:0] backIndex;
  logic [2:0] h, x;
  logic [15:0] lf, w;
  logic [15:0] pal [2][16];
  logic [39:0] hd;
  row_format_type rowFormat, f;
  row_setup_type rowSetup, e, m;
  back_colour_type backColour;
  int failures, checked, cyc;
  osd_row_header_bg_palette uut (.*);
  video_mix_model mix (.*);
  // ****************
  // Helpers
  // ****************
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Optional read strobe right behind the write, same address
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic rb);
    @(posedge ref_clk);
    regAddr <= ad;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regRead <= rb;
    if (rb) begin
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 chk(regRdData, d);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {regWrite, regRead, rowStart, rowDone, doubleWidthAttr, doubleHeightAttr} = '0;
    {extendedPalette, prevItalic, charFlashing, regAddr, regWrData, rowBase, backIndex} = '0;
    rowFormat = FMT_SERIAL;
    reset_n = 1'b0;
    lf = 16'h80CA;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(8'hFF, 8'h5A, 1'b1);
    for (int i = 0; i < 32; i++) begin
      lf = nx(lf);
      pal[i / 16][i % 16] = lf;
      // Entries 0 and 1 pin opacity to its two extremes
      if (i % 16 < 2) pal[i / 16][i % 16][11:9] = (i % 16) ? 3'h7 : 3'h0;
      // Entry 0 backs the leading space, so it switches at once
      if (i % 16 == 0) pal[i / 16][i % 16][15] = 1'b0;
      w = pal[i / 16][i % 16];
      wr((i < 16 ? 8'h30 : 8'h70) + 8'(2 * (i % 16)), w[15:8], 1'b1);
      wr((i < 16 ? 8'h30 : 8'h70) + 8'(2 * (i % 16) + 1), w[7:0], 1'b1);
    end
    for (int i = 0; i < 32; i++) begin
      lf = nx(lf);
      w = pal[i / 16][i % 16];
      @(posedge ref_clk);
      backIndex <= 4'(i % 16);
      extendedPalette <= (i >= 16);
      prevItalic <= lf[0];
      @(posedge ref_clk);
      #1 chk(backColour, {w[15] | lf[0], w[11:0]});
      chk(videoOnly, w[11:9] == 3'h0);
      @(posedge ref_clk);
      #1 chk(shownRgb, (w[11:9] == 3'h0) ? 9'h000 : w[8:0]);
    end
    for (int r = 0; r < 40; r++) begin
      lf = nx(lf);
      hd[39:24] = lf;
      lf = nx(lf);
      hd[23:8] = (r < 2) ? (r ? 16'hF7FF : 16'hFC01) : lf;
      if (hd[17:8] == 10'h000) hd[8] = 1'b1;
      lf = nx(lf);
      {b, a} = {2'h1, lf[15:11], 1'b0, lf[7:0]};
      hd[7:0] = a;
      f = row_format_type'(r % 4);
      {dw, dh} = lf[9:8];
      for (int j = 0; j < 5; j++) wr(b + 8'(j), hd[39 - 8 * j -: 8], 1'b0);
      @(posedge ref_clk);
      rowBase <= {1'b0, b};
      rowFormat <= f;
      {doubleWidthAttr, doubleHeightAttr, rowStart} <= {dw, dh, 1'b1};
      @(posedge ref_clk);
      rowStart <= 1'b0;
      for (int t = 0; t < 20 && rowActive !== 1'b1; t++) begin
        @(posedge ref_clk);
        #1;
      end
      chk(rowActive, 1'b1);
      wr(b + 8'h04, ~a, 1'b0);
      dw = dw & (f != FMT_BASIC);
      dh = dh & (f != FMT_BASIC);
      h = a[7] ? 3'(1 << ({1'b0, a[4]} + dh)) : (a[4] ? 3'h4 : 3'h2);
      x = a[7] ? 3'(1 << ({1'b0, a[3]} + dw)) : 3'(2 + a[4] + a[3]);
      e = {hd[32:25], 1'b0, hd[39:38], hd[23:8], 1'b0, 12'(({2'h0, hd[17:8]} + 12'h02F) * 2),
        a[7:6], h, x, a[2] & (f != FMT_BASIC), a[1] & !(a[7] && h == 3'h1 && x == 3'h1), a[0]};
      if (f == FMT_SERIAL && hd[23:18] > 6'h3D) e.charsPerRow = 6'h3D;
      m = '1;
      e.topHalf = a[6] & a[7] & dh;
      #1 chk(rowSetup & m, e & m);
      @(posedge ref_clk);
      charFlashing <= 1'b1;
      #1 chk(backBlank, 1'b0);
      @(posedge ref_clk);
      {charFlashing, rowDone} <= 2'h1;
      #1 chk(backBlank, e.blinkOn);
      @(posedge ref_clk);
      rowDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk(rowActive, 1'b0);
    end
    give_verdict();
  end
endmodule // tb
`default_nettype wire
